//--- sse_execute.sv
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
// Operation
// - Left logical shift of source A, zeros fill low bits, to target.
// - Arithmetic right shift copies source A sign bit into vacated bits.
// - Logical right shift of source A, zeros fill high bits, to target.
// - Shift amount is low five bits of source B or immediate.
// - Zero shift amount passes source A unchanged to target.
// - Shifts never touch condition codes and never trap.
// - Plain stores address source A plus source B or sign-extended immediate.
// - Word store writes full target register at effective address.
// - Trapping word store leaves memory untouched.
// - Word store traps only misaligned address or data access fault.
// - Byte store writes low target byte; only data access fault traps.
// - Alternate word store uses space id, address source A plus B.
// - Alternate byte store writes low byte into named space.
// - Alternate stores: immediate gives illegal, user mode gives privileged trap.
// - Trapping alternate store leaves memory untouched.
// - Coprocessor store writes coprocessor register word at effective address.
// - Condition-register store writes coprocessor condition register.
// - Coprocessor stores trap disabled when enable off or absent.
// - Coprocessor stores may trap exception, misaligned or data fault.
// - Fields: target 29..25, op 24..19, A 18..14, select 13, B 4..0.
module sse_execute
	import sse_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic memReq,
	output logic [31:0] memAddr,
	output logic [7:0] memAsi,
	output logic memAlt,
	output logic memWrite,
	output logic [31:0] memData,
	output logic [3:0] memByteEn,
	input wire logic memAck,
	input wire logic memFault,
	input wire logic cpPresent,
	input wire logic cpExcept,
	output logic [4:0] cpRegSel,
	input wire logic [31:0] cpRegData,
	input wire logic [31:0] cpCondData
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		sse_state_t state;
		logic [31:0] instr;
		logic [31:0] srcA;
		logic [31:0] srcB;
		logic [31:0] tgt;
		logic sup;
		logic cpEn;
		logic [3:0] icc;
		logic [31:0] result;
		logic resWr;
		logic done;
		sse_trap_t trap;
		logic [31:0] addr;
		logic [31:0] wData;
		logic [3:0] byteEn;
		logic [7:0] asi;
		logic alt;
		logic aWr;
		logic [7:0] aOff;
		logic [31:0] rdata;
	} sse_regs_t;

	sse_regs_t s;
	sse_regs_t next_s;

	// ----------------------------------------
	// Decode of the held instruction
	// ----------------------------------------
	logic [5:0] opc;
	logic selImm;
	logic [4:0] shAmt;
	logic [31:0] immExt;
	logic [31:0] effAddr;
	logic [31:0] shRes;
	logic isShift, isAlt, isByte, isCp, isStore;
	sse_shift_t shOp;
	sse_trap_t decTrap;

	// Field extraction and effective address
	assign opc = s.instr[OP_HI:OP_LO];
	assign selImm = s.instr[SEL_BIT];
	assign immExt = 32'($signed(s.instr[IMM_HI:0]));
	assign shAmt = selImm ? s.instr[RSB_HI:RSB_LO] : s.srcB[RSB_HI:RSB_LO];
	assign effAddr = s.srcA + ((selImm && !isAlt) ? immExt : s.srcB);
	assign isShift = (opc == OPC_SLL) || (opc == OPC_SRL) ||
		(opc == OPC_SHRS);
	assign isAlt = (opc == OPC_STWA) || (opc == OPC_STBA);
	assign isByte = (opc == OPC_STB) || (opc == OPC_STBA);
	assign isCp = (opc == OPC_CPREG) || (opc == OPC_CPCOND);
	assign isStore = isAlt || isCp || (opc == OPC_STW) || (opc == OPC_STB);
	assign shOp = (opc == OPC_SLL) ? SH_LEFT :
		(opc == OPC_SHRS) ? SH_RIGHT_SIGN : SH_RIGHT;

	sse_shifter u_shifter (
		.value(s.srcA),
		.amount(shAmt),
		.op(shOp),
		.result(shRes)
	);

	// Trap priority before any memory traffic
	always_comb begin
		decTrap = TRAP_NONE;
		if (isAlt && selImm) begin
			decTrap = TRAP_ILLEGAL;
		end else if (isAlt && !s.sup) begin
			decTrap = TRAP_PRIV;
		end else if (isCp && (!s.cpEn || !cpPresent)) begin
			decTrap = TRAP_CPDIS;
		end else if (!isByte && (effAddr[1:0] != 2'h0)) begin
			decTrap = TRAP_ALIGN;
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.aWr = 1'b0;
		// AHB address phase, read data prepared here
		if (hsel && htrans[1] && hready) begin
			next_s.aWr = hwrite;
			next_s.aOff = haddr[OFF_HI:0];
			case (haddr[OFF_HI:0])
				OFF_INSTR: next_s.rdata = s.instr;
				OFF_SRCA: next_s.rdata = s.srcA;
				OFF_SRCB: next_s.rdata = s.srcB;
				OFF_TGT: next_s.rdata = s.tgt;
				OFF_MODE: next_s.rdata = {24'h000000, s.icc, 2'h0, s.cpEn, s.sup};
				OFF_RESULT: next_s.rdata = s.result;
				OFF_STATUS: next_s.rdata = {19'h00000, s.instr[RD_HI:RD_LO],
					s.trap, 1'b0, s.resWr, s.done, (s.state != PH_IDLE)};
				default: next_s.rdata = 32'h00000000;
			endcase
		end
		// AHB data phase writes, operands frozen while busy
		if (s.aWr && (s.state == PH_IDLE)) begin
			case (s.aOff)
				OFF_INSTR: begin
					next_s.instr = hwdata;
					next_s.done = 1'b0;
					next_s.resWr = 1'b0;
					next_s.trap = TRAP_NONE;
					next_s.state = PH_DECODE;
				end
				OFF_SRCA: next_s.srcA = hwdata;
				OFF_SRCB: next_s.srcB = hwdata;
				OFF_TGT: next_s.tgt = hwdata;
				OFF_MODE: begin
					next_s.sup = hwdata[MODE_SUP];
					next_s.cpEn = hwdata[MODE_CPEN];
					next_s.icc = hwdata[MODE_ICC_HI:MODE_ICC_LO];
				end
				default: ;
			endcase
		end
		// Execute sequence
		unique case (s.state)
			PH_IDLE: ;
			PH_DECODE: begin
				if (isShift) begin
					next_s.result = shRes;
					next_s.resWr = 1'b1;
					next_s.done = 1'b1;
					next_s.state = PH_IDLE;
				end else if (!isStore) begin
					next_s.trap = TRAP_UNIMP;
					next_s.done = 1'b1;
					next_s.state = PH_IDLE;
				end else if (decTrap != TRAP_NONE) begin
					next_s.trap = decTrap;
					next_s.done = 1'b1;
					next_s.state = PH_IDLE;
				end else begin
					next_s.addr = effAddr;
					next_s.alt = isAlt;
					next_s.asi = isAlt ? s.instr[ASI_HI:ASI_LO] : 8'h00;
					if (isByte) begin
						// Low byte in every lane, one lane enabled
						next_s.wData = {4{s.tgt[7:0]}};
						next_s.byteEn = 4'h8 >> effAddr[1:0];
					end else begin
						next_s.wData = s.tgt;
						next_s.byteEn = 4'hF;
					end
					next_s.state = PH_PROBE;
				end
			end
			PH_PROBE: begin
				// Fault known before the strobe, so memory stays clean
				if (isCp && cpExcept) begin
					next_s.trap = TRAP_CPEXC;
					next_s.done = 1'b1;
					next_s.state = PH_IDLE;
				end else if (memFault) begin
					next_s.trap = TRAP_DACC;
					next_s.done = 1'b1;
					next_s.state = PH_IDLE;
				end else if (memAck) begin
					if (opc == OPC_CPREG) begin
						next_s.wData = cpRegData;
					end else if (opc == OPC_CPCOND) begin
						next_s.wData = cpCondData;
					end
					next_s.state = PH_WRITE;
				end
			end
			PH_WRITE: begin
				next_s.done = 1'b1;
				next_s.state = PH_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.state <= PH_IDLE;
			s.trap <= TRAP_NONE;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign hrdata = s.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign memReq = (s.state == PH_PROBE);
	assign memWrite = (s.state == PH_WRITE);
	assign memAddr = s.addr;
	assign memAsi = s.asi;
	assign memAlt = s.alt;
	assign memData = s.wData;
	assign memByteEn = s.byteEn;
	assign cpRegSel = s.instr[RD_HI:RD_LO];

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	logic [4:0] refAmt;
	logic decShift;
	assign refAmt = s.instr[13] ? s.instr[4:0] : s.srcB[4:0];
	assign decShift = (s.state == PH_DECODE) && isShift;

	shl_result_a: assert property (
		(s.state == PH_DECODE && opc == OPC_SLL) |=>
		s.result == ($past(s.srcA) << $past(refAmt)) && s.resWr)
		else $error("left shift result wrong");
	asr_result_a: assert property (
		(s.state == PH_DECODE && opc == OPC_SHRS) |=>
		s.result == 32'($signed($past(s.srcA)) >>> $past(refAmt)))
		else $error("arithmetic shift result wrong");
	srl_result_a: assert property (
		(s.state == PH_DECODE && opc == OPC_SRL) |=>
		s.result == ($past(s.srcA) >> $past(refAmt)))
		else $error("logical right shift result wrong");
	zero_shift_a: assert property (
		(decShift && refAmt == 5'h00) |=> s.result == $past(s.srcA))
		else $error("zero shift changed value");
	shift_quiet_a: assert property (
		decShift |=> s.trap == TRAP_NONE && $stable(s.icc) && !memReq)
		else $error("shift trapped or touched codes");
	write_clean_a: assert property (
		memWrite |-> $past(memReq) && $past(memAck) && !$past(memFault)
		&& s.trap == TRAP_NONE)
		else $error("write strobe without clean probe");
	priv_trap_a: assert property (
		(s.state == PH_DECODE && isAlt && !selImm && !s.sup) |=>
		s.trap == TRAP_PRIV ##1 !memWrite)
		else $error("user alternate store not trapped");
	illegal_trap_a: assert property (
		(s.state == PH_DECODE && isAlt && selImm) |=>
		s.trap == TRAP_ILLEGAL && s.done)
		else $error("immediate alternate store not trapped");
	cp_disabled_a: assert property (
		(s.state == PH_DECODE && isCp && (!s.cpEn || !cpPresent)) |=>
		s.trap == TRAP_CPDIS && !memReq)
		else $error("disabled coprocessor store not trapped");
	align_trap_a: assert property (
		(s.state == PH_DECODE && opc == OPC_STW && effAddr[1:0] != 2'h0)
		|=> s.trap == TRAP_ALIGN)
		else $error("misaligned word store not trapped");
	byte_lane_a: assert property (
		(memWrite && isByte) |-> $countones(memByteEn) == 1
		&& memData[7:0] == s.tgt[7:0])
		else $error("byte store lanes wrong");
	word_data_a: assert property (
		(memWrite && opc == OPC_STW) |-> memData == s.tgt
		&& memByteEn == 4'hF && memAddr[1:0] == 2'h0)
		else $error("word store data wrong");

	// Probe outcomes and the data that reach the bus
	cp_exc_trap_a: assert property (
		(s.state == PH_PROBE && isCp && cpExcept) |=>
		s.trap == TRAP_CPEXC && s.done && !memWrite)
		else $error("coprocessor exception not trapped");
	fault_trap_a: assert property (
		(s.state == PH_PROBE && memFault && !(isCp && cpExcept)) |=>
		s.trap == TRAP_DACC && !memWrite)
		else $error("data access fault not trapped");
	alt_space_a: assert property (
		(memWrite && isAlt) |-> memAlt && memAsi == s.instr[12:5])
		else $error("alternate space id wrong");
	cp_data_a: assert property (
		(s.state == PH_PROBE && memAck && !memFault && !cpExcept && isCp)
		|=> memData == ((opc == OPC_CPREG) ? $past(cpRegData) :
		$past(cpCondData)))
		else $error("coprocessor store data wrong");

	shift_done_c: cover property (decShift ##1 s.done);
	word_write_c: cover property (memWrite && opc == OPC_STW);
	alt_write_c: cover property (memWrite && memAlt);
	cp_trap_c: cover property (s.trap == TRAP_CPEXC);

endmodule // sse_execute

//--- sse_pkg.sv
package sse_pkg;

	// ----------------------------------------
	// Register map, byte addresses
	// ----------------------------------------
	localparam logic [7:0] OFF_INSTR = 8'h00;
	localparam logic [7:0] OFF_SRCA = 8'h04;
	localparam logic [7:0] OFF_SRCB = 8'h08;
	localparam logic [7:0] OFF_TGT = 8'h0C;
	localparam logic [7:0] OFF_MODE = 8'h10;
	localparam logic [7:0] OFF_RESULT = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	localparam int OFF_HI = 7;

	// ----------------------------------------
	// Field layouts
	// ----------------------------------------
	localparam int RD_HI = 29;
	localparam int RD_LO = 25;
	localparam int OP_HI = 24;
	localparam int OP_LO = 19;
	localparam int RSA_HI = 18;
	localparam int RSA_LO = 14;
	localparam int SEL_BIT = 13;
	localparam int ASI_HI = 12;
	localparam int ASI_LO = 5;
	localparam int IMM_HI = 12;
	localparam int RSB_HI = 4;
	localparam int RSB_LO = 0;
	localparam int MODE_SUP = 0;
	localparam int MODE_CPEN = 1;
	localparam int MODE_ICC_HI = 7;
	localparam int MODE_ICC_LO = 4;

	// Operation codes
	localparam logic [5:0] OPC_SLL = 6'h25;
	localparam logic [5:0] OPC_SRL = 6'h26;
	localparam logic [5:0] OPC_SHRS = 6'h27;
	localparam logic [5:0] OPC_STW = 6'h04;
	localparam logic [5:0] OPC_STB = 6'h05;
	localparam logic [5:0] OPC_STWA = 6'h14;
	localparam logic [5:0] OPC_STBA = 6'h15;
	localparam logic [5:0] OPC_CPREG = 6'h34;
	localparam logic [5:0] OPC_CPCOND = 6'h35;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		SH_LEFT = 2'h0,
		SH_RIGHT = 2'h1,
		SH_RIGHT_SIGN = 2'h2
	} sse_shift_t;

	typedef enum logic [3:0] {
		PH_IDLE = 4'h1,
		PH_DECODE = 4'h2,
		PH_PROBE = 4'h4,
		PH_WRITE = 4'h8
	} sse_state_t;

	typedef enum logic [3:0] {
		TRAP_NONE = 4'h0,
		TRAP_UNIMP = 4'h1,
		TRAP_ILLEGAL = 4'h2,
		TRAP_PRIV = 4'h3,
		TRAP_CPDIS = 4'h4,
		TRAP_CPEXC = 4'h5,
		TRAP_ALIGN = 4'h6,
		TRAP_DACC = 4'h7
	} sse_trap_t;

endpackage

//--- sse_shifter.sv
`timescale 1ns/1ns
module sse_shifter
	import sse_pkg::*;
(
	input wire logic [31:0] value,
	input wire logic [4:0] amount,
	input sse_shift_t op,
	output logic [31:0] result
);

	// ----------------------------------------
	// Barrel shift, zero amount passes through
	// ----------------------------------------
	always_comb begin
		unique case (op)
			SH_LEFT: result = value << amount;
			SH_RIGHT: result = value >> amount;
			SH_RIGHT_SIGN: result = 32'($signed(value) >>> amount);
			default: result = value;
		endcase
	end

endmodule // sse_shifter

//--- sse_mem_model.sv
`timescale 1ns/1ns
module sse_mem_model (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic memReq,
	input wire logic memWrite,
	input wire logic [31:0] memAddr,
	input wire logic [31:0] memData,
	input wire logic [3:0] memByteEn,
	input wire logic [4:0] cpRegSel,
	input wire logic [1:0] ansMode,
	input wire logic [1:0] ansDelay,
	output logic memAck,
	output logic memFault,
	output logic cpExcept,
	output logic [31:0] cpRegData,
	output logic [31:0] cpCondData,
	output int wrCount,
	output logic [31:0] wrAddr,
	output logic [31:0] wrData,
	output logic [3:0] wrBe
);
	int waitCnt;
	logic hit;
	logic [31:0] regWord;

	// Coprocessor words, scrambled while nobody asks
	assign regWord = {8'hC5, 19'h0, cpRegSel};
	assign cpRegData = memReq ? regWord : ~regWord;
	assign cpCondData = memReq ? 32'h00C0FFEE : 32'hFF3F0011;
	assign hit = memReq && waitCnt == int'(ansDelay);

	// Answer after a chosen delay, log accepted writes
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			waitCnt <= 0;
			memAck <= 1'b0;
			memFault <= 1'b0;
			cpExcept <= 1'b0;
			wrCount <= 0;
		end else begin
			waitCnt <= memReq ? waitCnt + 1 : 0;
			memAck <= hit && ansMode == 2'h0;
			memFault <= hit && ansMode == 2'h1;
			cpExcept <= hit && ansMode == 2'h2;
			if (memWrite) begin
				wrCount <= wrCount + 1;
				wrAddr <= memAddr;
				wrData <= memData;
				wrBe <= memByteEn;
			end
		end
	end
endmodule // sse_mem_model

//--- tb_top.sv
`timescale 1ns/1ns
module tb_top
	import sse_pkg::*;
;
	logic mclk, resetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, memAddr, memData, cpRegData;
	logic [31:0] cpCondData, wrAddr, wrData;
	logic [1:0] htrans, ansMode, ansDelay;
	logic [2:0] hsize;
	logic [7:0] memAsi;
	logic [3:0] memByteEn, wrBe;
	logic [4:0] cpRegSel;
	logic memReq, memAlt, memWrite, memAck, memFault, cpPresent, cpExcept;
	int wrCount, miscompares, checks_done;
	logic [5:0] shOp [3] = '{OPC_SLL, OPC_SRL, OPC_SHRS};

	assign hready = hreadyout;
	always #10 mclk = ~mclk;

	sse_execute dut_u (.mclk(mclk), .resetn(resetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .memReq(memReq),
		.memAddr(memAddr), .memAsi(memAsi), .memAlt(memAlt),
		.memWrite(memWrite), .memData(memData), .memByteEn(memByteEn),
		.memAck(memAck), .memFault(memFault), .cpPresent(cpPresent),
		.cpExcept(cpExcept), .cpRegSel(cpRegSel), .cpRegData(cpRegData),
		.cpCondData(cpCondData));

	sse_mem_model mem_u (.mclk(mclk), .resetn(resetn), .memReq(memReq),
		.memWrite(memWrite), .memAddr(memAddr), .memData(memData),
		.memByteEn(memByteEn), .cpRegSel(cpRegSel), .ansMode(ansMode),
		.ansDelay(ansDelay), .memAck(memAck), .memFault(memFault),
		.cpExcept(cpExcept), .cpRegData(cpRegData),
		.cpCondData(cpCondData), .wrCount(wrCount), .wrAddr(wrAddr),
		.wrData(wrData), .wrBe(wrBe));

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	// One single AHB transfer, address phase then data phase
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge mclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hready !== 1'b1);
		q = hrdata;
	endtask

	function automatic logic [31:0] al(input logic [1:0] lb);
		return {30'($urandom), lb};
	endfunction

	// md: bit0 supervisor, bit1 coproc enable, bit2 coprocessor attached
	task automatic runOne(input logic [5:0] op, input logic iBit,
		input logic [2:0] md, input logic [1:0] fm,
		input logic [31:0] a, input logic [31:0] b, input logic [12:0] lo);
		logic [31:0] ins, tg, ea, ex, dat, stat, q;
		logic [4:0] amt, rd;
		logic [3:0] trap, icc;
		logic shf, alt, wd, cp;
		int n0;
		tg = $urandom;
		rd = 5'($urandom);
		icc = 4'($urandom);
		shf = op == OPC_SLL || op == OPC_SRL || op == OPC_SHRS;
		alt = op == OPC_STWA || op == OPC_STBA;
		cp = op == OPC_CPREG || op == OPC_CPCOND;
		wd = op == OPC_STW || op == OPC_STWA || cp;
		ins = {shf ? 2'h2 : 2'h3, rd, op, 5'($urandom), iBit, lo};
		ea = a + ((iBit && !alt) ? {{19{lo[12]}}, lo} : b);
		amt = iBit ? lo[4:0] : b[4:0];
		trap = 4'h0;
		if (!shf && !wd && op != OPC_STB && op != OPC_STBA) trap = 4'h1;
		else if (alt && iBit) trap = 4'h2;
		else if (alt && !md[0]) trap = 4'h3;
		else if (cp && md[2:1] != 2'h3) trap = 4'h4;
		else if (wd && ea[1:0] != 2'h0) trap = 4'h6;
		else if (cp && fm == 2'h2) trap = 4'h5;
		else if (!shf && fm != 2'h0) trap = 4'h7;
		ex = op == OPC_SLL ? a << amt : op == OPC_SRL ? a >> amt :
			32'($signed(a) >>> amt);
		dat = op == OPC_CPREG ? {8'hC5, 19'h0, rd} : op == OPC_CPCOND ?
			32'h00C0FFEE : wd ? tg : {4{tg[7:0]}};
		ansMode <= fm;
		ansDelay <= 2'($urandom);
		cpPresent <= md[2];
		n0 = wrCount;
		bus(1'b1, OFF_SRCA, a, q);
		bus(1'b1, OFF_SRCB, b, q);
		bus(1'b1, OFF_TGT, tg, q);
		bus(1'b1, OFF_MODE, {24'h0, icc, 2'h0, md[1:0]}, q);
		bus(1'b1, OFF_INSTR, ins, q);
		do bus(1'b0, OFF_STATUS, 32'h0, stat); while (stat[1:0] !== 2'h2);
		check({23'h0, stat[12:4]}, {23'h0, rd, trap});
		if (shf) begin
			bus(1'b0, OFF_RESULT, 32'h0, q);
			check(q, ex);
			check(32'(stat[2]), 32'h1);
			bus(1'b0, OFF_MODE, 32'h0, q);
			check(32'(q[7:4]), 32'(icc));
		end else begin
			check(32'(wrCount - n0), 32'(trap == 4'h0));
			if (trap == 4'h0) begin
				check(wrAddr, ea);
				check(wrData, dat);
				check(32'(wrBe), wd ? 32'hF : 32'(4'h8 >> ea[1:0]));
				check(32'(memAlt), 32'(alt));
				if (alt) check(32'(memAsi), 32'(ins[12:5]));
			end
		end
	endtask

	initial begin
		logic [31:0] q;
		mclk = 1'b0;
		resetn = 1'b0;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		cpPresent = 1'b1;
		ansMode = 2'h0;
		ansDelay = 2'h0;
		miscompares = 0;
		checks_done = 0;
		void'($urandom(32'hB857A8A1));
		repeat (8) @(posedge mclk);
		resetn <= 1'b1;
		foreach (shOp[k]) begin
			runOne(shOp[k], 1'b0, 3'h7, 2'h0, $urandom | 32'h80000000,
				$urandom, 13'h0);
			runOne(shOp[k], 1'b1, 3'h7, 2'h0, $urandom | 32'h80000000,
				$urandom, 13'h1FFF);
			runOne(shOp[k], 1'b1, 3'h7, 2'h0, $urandom, 0, 13'h1000);
			runOne(shOp[k], 1'b0, 3'h7, 2'h0, $urandom, 32'hFFFFFFE0,
				13'h0);
		end
		runOne(OPC_STW, 1'b0, 3'h7, 2'h0, al(0), al(0), 13'h0);
		runOne(OPC_STW, 1'b1, 3'h7, 2'h0, al(0), 0, 13'h1FF8);
		runOne(OPC_STW, 1'b0, 3'h7, 2'h0, al(0), al(2), 13'h0);
		runOne(OPC_STW, 1'b0, 3'h7, 2'h1, al(0), al(0), 13'h0);
		runOne(OPC_STB, 1'b1, 3'h7, 2'h0, al(3), 0, 13'h0);
		runOne(OPC_STB, 1'b0, 3'h7, 2'h1, al(1), al(0), 13'h0);
		runOne(OPC_STWA, 1'b0, 3'h7, 2'h0, al(0), al(0), 13'h1AB);
		runOne(OPC_STWA, 1'b1, 3'h7, 2'h0, al(0), al(0), 13'h0);
		runOne(OPC_STWA, 1'b0, 3'h6, 2'h0, al(0), al(0), 13'h0);
		runOne(OPC_STWA, 1'b0, 3'h7, 2'h1, al(0), al(0), 13'h0);
		runOne(OPC_STBA, 1'b0, 3'h7, 2'h0, al(2), al(0), 13'h0E0);
		runOne(OPC_STBA, 1'b0, 3'h6, 2'h0, al(1), al(0), 13'h0);
		runOne(OPC_CPREG, 1'b0, 3'h7, 2'h0, al(0), al(0), 13'h0);
		runOne(OPC_CPREG, 1'b0, 3'h5, 2'h0, al(0), al(0), 13'h0);
		runOne(OPC_CPREG, 1'b0, 3'h3, 2'h0, al(0), al(0), 13'h0);
		runOne(OPC_CPREG, 1'b1, 3'h7, 2'h2, al(0), 0, 13'h4);
		runOne(OPC_CPREG, 1'b0, 3'h7, 2'h0, al(0), al(1), 13'h0);
		runOne(OPC_CPCOND, 1'b0, 3'h7, 2'h0, al(0), al(0), 13'h0);
		runOne(OPC_CPCOND, 1'b0, 3'h7, 2'h1, al(0), al(0), 13'h0);
		runOne(6'h3F, 1'b0, 3'h7, 2'h0, al(0), al(0), 13'h0);
		bus(1'b0, 8'h40, 32'h0, q);
		check(q, 32'h0);
		check(32'(hresp), 32'h0);
		end_of_test();
	end

	// Cut a hang short
	initial begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		end_of_test();
	end
endmodule // tb_top
